// File: logic/display_rail_enable_sequencer.sv
`timescale 1ns/1ps
module display_rail_enable_sequencer #(
    parameter int neg_delay_cycles = rail_seq_pkg::neg_delay_cycles
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_positive_rail_enable_pin,
    input wire logic i_negative_rail_enable_pin,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_bus_stop,
    input wire logic [7:0] i_rd_addr,
    input wire logic i_boost_ss_done,
    output logic [7:0] o_rd_data,
    output rail_seq_pkg::rail_out_s o_rails
);
    ////////////////////////////////////////////////////////////////
    // register: staged byte committed at stop
    logic [7:0] ctrl_r;
    logic [7:0] staged_r;
    logic staged_valid_r;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            staged_r <= 8'h00;
            staged_valid_r <= 1'b0;
        end else if (i_bus_stop) begin
            staged_valid_r <= 1'b0;
        end else if (i_wr_valid && i_wr_addr == rail_seq_pkg::rail_enable_control_addr) begin
            staged_r <= i_wr_data;
            staged_valid_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_r <= rail_seq_pkg::rail_enable_reset;
        end else if (i_bus_stop && staged_valid_r) begin
            ctrl_r <= staged_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= (i_rd_addr == rail_seq_pkg::rail_enable_control_addr) ? ctrl_r : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // register checks
    stop_commit_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        ctrl_r != $past(ctrl_r) |-> $past(i_bus_stop))
        else $error("register changed without stop");

    stage_commit_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_bus_stop && staged_valid_r |=> ctrl_r == $past(staged_r))
        else $error("staged byte not committed");

    stop_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_bus_stop |=> !staged_valid_r)
        else $error("staged byte kept after stop");

    wr_ignore_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_wr_valid && i_wr_addr != rail_seq_pkg::rail_enable_control_addr && !i_bus_stop |=> $stable(staged_r))
        else $error("foreign write staged");

    rd_data_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_rd_addr == rail_seq_pkg::rail_enable_control_addr |=> o_rd_data == $past(ctrl_r))
        else $error("read data wrong");

    rd_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_rd_addr != rail_seq_pkg::rail_enable_control_addr |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");

    ////////////////////////////////////////////////////////////////
    // enable conditions
    logic boost_en;
    logic pos_en;
    logic neg_req;
    assign boost_en = (i_positive_rail_enable_pin | i_negative_rail_enable_pin)
        & ctrl_r[rail_seq_pkg::boost_bit];
    assign pos_en = boost_en & i_boost_ss_done & i_positive_rail_enable_pin
        & ctrl_r[rail_seq_pkg::pos_bit];
    assign neg_req = boost_en & i_boost_ss_done & i_negative_rail_enable_pin
        & ctrl_r[rail_seq_pkg::neg_bit];

    ////////////////////////////////////////////////////////////////
    // negative rail delay counter
    logic [31:0] cnt_r;
    logic neg_on_r;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r <= 32'h0000_0000;
        end else if (!neg_req) begin
            cnt_r <= 32'h0000_0000;
        end else if (cnt_r < 32'(neg_delay_cycles)) begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            neg_on_r <= 1'b0;
        end else begin
            neg_on_r <= neg_req && (cnt_r >= 32'(neg_delay_cycles) - 32'h0000_0001);
        end
    end

    ////////////////////////////////////////////////////////////////
    // negative rail checks
    neg_waits_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(o_rails.neg_on) |-> $past(cnt_r) == 32'(neg_delay_cycles) - 32'h0000_0001)
        else $error("negative rail early");

    neg_due_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        neg_req && cnt_r >= 32'(neg_delay_cycles) - 32'h0000_0001 |=> o_rails.neg_on)
        else $error("negative rail late");

    neg_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        neg_req && cnt_r < 32'(neg_delay_cycles) - 32'h0000_0001 |=> !o_rails.neg_on)
        else $error("negative rail before delay");

    cnt_restart_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !neg_req |=> cnt_r == 32'h0000_0000)
        else $error("counter not restarted");

    cnt_cap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        cnt_r <= 32'(neg_delay_cycles))
        else $error("delay counter overran");

    neg_bit_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !ctrl_r[rail_seq_pkg::neg_bit] |=> !o_rails.neg_on)
        else $error("negative rail on with bit clear");

    neg_ss_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_boost_ss_done |=> !o_rails.neg_on)
        else $error("negative rail before soft-start");

    neg_pin_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_negative_rail_enable_pin |=> !o_rails.neg_on)
        else $error("negative rail on without pin");

    ////////////////////////////////////////////////////////////////
    // outputs: one flop per rail, packed into the carrier
    logic boost_on_r;
    logic pos_on_r;
    logic pos_pulldown_r;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            boost_on_r <= 1'b0;
        end else begin
            boost_on_r <= boost_en;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pos_on_r <= 1'b0;
        end else begin
            pos_on_r <= pos_en;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pos_pulldown_r <= 1'b0;
        end else begin
            pos_pulldown_r <= !pos_en && !ctrl_r[rail_seq_pkg::hiz_bit];
        end
    end

    assign o_rails = {boost_on_r, pos_on_r, neg_on_r, pos_pulldown_r};

    ////////////////////////////////////////////////////////////////
    // output checks
    pos_needs_pin_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_rails.pos_on |-> $past(i_positive_rail_enable_pin) && $past(ctrl_r[rail_seq_pkg::pos_bit]))
        else $error("positive rail on without pin");

    pos_on_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        pos_en |=> o_rails.pos_on)
        else $error("positive rail not on");

    pos_ss_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_boost_ss_done |=> !o_rails.pos_on)
        else $error("positive rail before soft-start");

    pos_bit_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !ctrl_r[rail_seq_pkg::pos_bit] |=> !o_rails.pos_on)
        else $error("positive rail on with bit clear");

    pos_pin_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_positive_rail_enable_pin |=> !o_rails.pos_on)
        else $error("positive rail on after pin low");

    both_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_positive_rail_enable_pin && !i_negative_rail_enable_pin |=> !o_rails.pos_on && !o_rails.neg_on
        && !o_rails.boost_on)
        else $error("rails not off together");

    boost_run_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_positive_rail_enable_pin || i_negative_rail_enable_pin) && ctrl_r[rail_seq_pkg::boost_bit]
        |=> o_rails.boost_on)
        else $error("boost not running");

    boost_stop_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !ctrl_r[rail_seq_pkg::boost_bit] |=> !o_rails.boost_on)
        else $error("boost running with bit clear");

    hiz_pull_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        ctrl_r[rail_seq_pkg::hiz_bit] |=> !o_rails.pos_pulldown_on)
        else $error("pull-down in hi-z");

    pull_on_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !pos_en && !ctrl_r[rail_seq_pkg::hiz_bit] |=> o_rails.pos_pulldown_on)
        else $error("pull-down missing while off");

    pull_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_rails.pos_on |-> !o_rails.pos_pulldown_on)
        else $error("pull-down while rail on");
endmodule

// File: include/rail_seq_pkg.sv
// What this block does
// - bit1 gates negative rail, bit2 positive rail
// - written enable byte applies at bus stop
// - one write all bits: positive first, negative delayed
// - pins work while enable bits hold default one
// - negative rail starts fixed delay after pin
// - both pins rise: positive first, negative later
// - both pins fall: both rails stop together
// - hi-z bit disables positive pull-down when off
// - boost runs on either pin and bit0
// - negative delay counts from later of boost-done, pin
// - positive rail needs pin and boost soft-start done
// - own pin low stops rail; both stop boost
package rail_seq_pkg;
    localparam logic [7:0] rail_enable_control_addr = 8'h05;
    localparam logic [7:0] rail_enable_reset = 8'h07;
    localparam int boost_bit = 0;
    localparam int neg_bit = 1;
    localparam int pos_bit = 2;
    localparam int hiz_bit = 3;
    localparam int clk_hz = 50_000_000;
    localparam int neg_delay_us = 2000;
    localparam int neg_delay_cycles = (clk_hz / 1_000_000) * neg_delay_us;

    typedef struct packed {
        logic boost_on;
        logic pos_on;
        logic neg_on;
        logic pos_pulldown_on;
    } rail_out_s;
endpackage

// File: tb/rail_host_model.sv
`timescale 1ns/1ps
module rail_host_model (
    input wire logic i_clk,
    output logic o_wr_valid = 1'b0,
    output logic [7:0] o_wr_addr = 8'h00,
    output logic [7:0] o_wr_data = 8'hff,
    output logic o_bus_stop = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {o_wr_valid, o_wr_addr, o_wr_data} = {1'b1, a, d};
        @(negedge i_clk);
        {o_wr_valid, o_bus_stop, o_wr_addr, o_wr_data} = {2'b01, ~a, ~d};
        @(negedge i_clk);
        o_bus_stop = 1'b0;
    endtask
endmodule

// File: tb/display_rail_enable_sequencer_tb_top.sv
`timescale 1ns/1ps
module display_rail_enable_sequencer_tb_top;
    localparam int dly = 10;
    logic i_clk = 1'b0, i_nrst = 1'b0, ss = 1'b1, pp = 1'b0, np = 1'b0, wv, bs;
    logic [7:0] rd_addr = 8'h05, wa, wd, rd;
    rail_seq_pkg::rail_out_s rails;
    int n_fail = 0, comparisons = 0, ctrl = 7, seed = 32'h710a;
    always #10 i_clk = ~i_clk;
    rail_host_model i_host (.i_clk(i_clk), .o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wd), .o_bus_stop(bs));
    display_rail_enable_sequencer #(.neg_delay_cycles(dly)) i_dut (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_positive_rail_enable_pin(pp), .i_negative_rail_enable_pin(np), .i_wr_valid(wv), .i_wr_addr(wa),
        .i_wr_data(wd), .i_bus_stop(bs), .i_rd_addr(rd_addr), .i_boost_ss_done(ss), .o_rd_data(rd), .o_rails(rails));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rails_chk(input int w, input logic n);
        logic b;
        logic p;
        repeat (w) @(negedge i_clk);
        b = (pp | np) & ctrl[rail_seq_pkg::boost_bit];
        p = b & pp & ctrl[rail_seq_pkg::pos_bit] & ss;
        chk("rails", {4'h0, b, p, n, !p & !ctrl[rail_seq_pkg::hiz_bit]}, {4'h0, rails});
        chk("ctrl", (rd_addr == rail_seq_pkg::rail_enable_control_addr) ? ctrl[7:0] : 8'h00, rd);
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic n);
        if (a == rail_seq_pkg::rail_enable_control_addr)
            ctrl = d;
        i_host.wr(a, d);
        rails_chk(2, n);
    endtask
    task automatic finish_test;
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge i_clk);
        n_fail++;
        finish_test;
    end
    initial begin
        repeat (3) @(negedge i_clk);
        i_nrst = 1'b1;
        rails_chk(2, 1'b0);
        {pp, np} = 2'b11;
        rails_chk(3, 1'b0);
        rails_chk(dly - 4, 1'b0);
        rails_chk(1, 1'b1);
        {pp, np} = 2'b00;
        rails_chk(1, 1'b0);
        {ss, pp, np} = 3'b011;
        rails_chk(3, 1'b0);
        ss = 1'b1;
        rails_chk(dly - 1, 1'b0);
        rails_chk(1, 1'b1);
        wr_chk(8'h05, 8'h03, 1'b1);
        wr_chk(8'h05, 8'h01, 1'b0);
        wr_chk(8'h05, 8'h07, 1'b0);
        rails_chk(dly - 3, 1'b0);
        rails_chk(1, 1'b1);
        rd_addr = {1'b1, 7'($random(seed))};
        wr_chk({1'b1, 7'($random(seed))}, 8'($random(seed)), 1'b1);
        rd_addr = rail_seq_pkg::rail_enable_control_addr;
        wr_chk(8'h05, 8'h06, 1'b0);
        {pp, np} = 2'b00;
        wr_chk(8'h05, 8'h0f, 1'b0);
        i_nrst = 1'b0;
        @(negedge i_clk);
        i_nrst = 1'b1;
        ctrl = 7;
        rails_chk(2, 1'b0);
        {pp, np} = 2'b11;
        rails_chk(dly - 1, 1'b0);
        rails_chk(1, 1'b1);
        finish_test;
    end
endmodule
